// *** hdl/dacsr_pkg.sv ***
// Constants, register map, state types of the dual converter readout.
// Assumes one 40 MHz system clock; pins arrive synchronous to it.
package dacsr_pkg;

    // ****************************************
    // Sizes and counts
    // ****************************************
    localparam int unsigned CLK_FREQ_HZ   = 40000000;
    localparam int unsigned CODE_BITS     = 12;
    localparam int unsigned FRAME_BITS    = 16;
    localparam logic [4:0]  CONV_CYCLES   = 5'h10;
    localparam logic [4:0]  BUSY_CLR_EDGE = 5'h0D;
    localparam logic [5:0]  FRAME_LEN_2   = 6'h10;
    localparam logic [5:0]  FRAME_LEN_1   = 6'h20;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] OFS_STATUS  = 12'h000;
    localparam logic [11:0] OFS_SAMPLE0 = 12'h004;
    localparam logic [11:0] OFS_SAMPLE1 = 12'h008;
    localparam logic [11:0] OFS_RESULT  = 12'h00C;
    localparam int unsigned FLD_A_LSB   = 0;
    localparam int unsigned FLD_B_LSB   = 16;
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0]
    {
        CONV_IDLE  = 3'h1,
        CONV_FETCH = 3'h2,
        CONV_RUN   = 3'h4
    } dacsr_conv_type;

    typedef enum logic [2:0]
    {
        SEL_NONE    = 3'h0,
        SEL_STATUS  = 3'h1,
        SEL_SAMPLE0 = 3'h2,
        SEL_SAMPLE1 = 3'h3,
        SEL_RESULT  = 3'h4
    } dacsr_sel_type;

    typedef struct packed
    {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } dacsr_apb_req_type;

    typedef struct packed
    {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } dacsr_apb_rsp_type;

    typedef struct packed
    {
        logic [1:0][23:0] word;
        logic [23:0]      rd;
    } dacsr_mem_type;

    typedef struct packed
    {
        dacsr_conv_type    conv;
        logic [4:0]        conv_cnt;
        logic              busy;
        logic              pair_next;
        logic              hold_pair;
        logic [23:0]       hold_code;
        logic              res_pair;
        logic [23:0]       res_code;
        logic              trig_prev;
        logic              sync_prev;
        logic              sclk_prev;
        logic              frame_on;
        logic              frame_single;
        logic [5:0]        bit_idx;
        logic              sdo_a;
        logic              sdo_b;
        logic              oe_a;
        logic              oe_b;
        dacsr_apb_rsp_type apb;
    } dacsr_state_type;

endpackage

// *** hdl/dacsr_sample_mem.sv ***
// Two-word store of digitised pair samples, written over the bus.
// Assumes one write and one registered read per clock.
`timescale 1ns/1ps
module dacsr_sample_mem
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_wr_en,
    input  wire logic        i_wr_addr,
    input  wire logic [23:0] i_wr_data,
    input  wire logic        i_rd_addr,
    output logic      [23:0] o_rd_data
);

    dacsr_pkg::dacsr_mem_type s_q;
    dacsr_pkg::dacsr_mem_type s_d;

    always_comb
    begin
        s_d = s_q;
        // Read sees the old word on a same-cycle write
        s_d.rd = s_q.word[i_rd_addr];
        if (i_wr_en)
        begin
            s_d.word[i_wr_addr] = i_wr_data;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_rd_data = s_q.rd;

endmodule

// *** hdl/dacsr_top.sv ***
// Conversion sequencer and serial readout of the dual converter.
// Assumes shift clock, trigger, sync and mode pins synchronous to i_clk.
`timescale 1ns/1ps
module dacsr_top
(
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_shift_clock,
    input  wire logic        i_conversion_trigger,
    input  wire logic        i_readout_sync,
    input  wire logic        i_chip_select_n,
    input  wire logic        i_channel_count_select,
    input  wire logic        i_output_port_select,
    input  wire logic        i_pair_select,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic      [31:0] o_prdata,
    output logic             o_busy,
    output logic             o_sdo_a,
    output logic             o_sdo_a_oe,
    output logic             o_sdo_b,
    output logic             o_sdo_b_oe
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic dacsr_pkg::dacsr_sel_type reg_sel(
        input logic [11:0] addr
    );
        if (addr == dacsr_pkg::OFS_STATUS)
            reg_sel = dacsr_pkg::SEL_STATUS;
        else if (addr == dacsr_pkg::OFS_SAMPLE0)
            reg_sel = dacsr_pkg::SEL_SAMPLE0;
        else if (addr == dacsr_pkg::OFS_SAMPLE1)
            reg_sel = dacsr_pkg::SEL_SAMPLE1;
        else if (addr == dacsr_pkg::OFS_RESULT)
            reg_sel = dacsr_pkg::SEL_RESULT;
        else
            reg_sel = dacsr_pkg::SEL_NONE;
    endfunction

    // Frame word: pair tag, channel tag, code MSB first, two zeros
    function automatic logic [15:0] frame_word(
        input logic        pair,
        input logic        chan_b,
        input logic [11:0] code
    );
        frame_word = {pair, chan_b, code, 2'h0};
    endfunction

    dacsr_pkg::dacsr_apb_req_type req;
    dacsr_pkg::dacsr_state_type   s_q;
    dacsr_pkg::dacsr_state_type   s_d;
    dacsr_pkg::dacsr_sel_type     sel;
    logic                         wr_en;
    logic                         rd_addr;
    logic [23:0]                  mem_rd;
    logic [23:0]                  wr_word;

    assign req     = '{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata};
    assign sel     = reg_sel(req.paddr);
    assign wr_en   = req.psel & req.penable & req.pwrite & s_q.apb.pready
                   & ((sel == dacsr_pkg::SEL_SAMPLE0)
                   | (sel == dacsr_pkg::SEL_SAMPLE1));
    assign wr_word = {req.pwdata[dacsr_pkg::FLD_B_LSB +: 12],
                      req.pwdata[dacsr_pkg::FLD_A_LSB +: 12]};
    // Address from the next state, so the word is ready in the fetch cycle
    assign rd_addr = s_d.hold_pair;

    dacsr_sample_mem u_mem
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_wr_en   (wr_en),
        .i_wr_addr (sel == dacsr_pkg::SEL_SAMPLE1),
        .i_wr_data (wr_word),
        .i_rd_addr (rd_addr),
        .o_rd_data (mem_rd)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        logic        sclk_rise;
        logic        trig_rise;
        logic        sync_rise;
        logic [15:0] word_a;
        logic [15:0] word_b;
        logic [5:0]  len;
        sclk_rise = 1'b0;
        trig_rise = 1'b0;
        sync_rise = 1'b0;
        word_a    = '0;
        word_b    = '0;
        len       = '0;
        s_d       = s_q;

        sclk_rise = i_shift_clock & ~s_q.sclk_prev;
        trig_rise = i_conversion_trigger & ~s_q.trig_prev;
        sync_rise = i_readout_sync & ~s_q.sync_prev;
        s_d.sclk_prev = i_shift_clock;
        s_d.trig_prev = i_conversion_trigger;
        s_d.sync_prev = i_readout_sync;

        case (s_q.conv)
            dacsr_pkg::CONV_IDLE:
            begin
                if (trig_rise)
                begin
                    s_d.conv     = dacsr_pkg::CONV_FETCH;
                    s_d.busy     = 1'b1;
                    s_d.conv_cnt = '0;
                    if (i_channel_count_select)
                    begin
                        s_d.hold_pair = s_q.pair_next;
                        s_d.pair_next = ~s_q.pair_next;
                    end
                    else
                    begin
                        s_d.hold_pair = i_pair_select;
                        s_d.pair_next = 1'b0;
                    end
                end
            end
            dacsr_pkg::CONV_FETCH:
            begin
                // Memory read lands one clock after the address
                s_d.conv      = dacsr_pkg::CONV_RUN;
                s_d.hold_code = mem_rd;
            end
            dacsr_pkg::CONV_RUN:
            begin
                if (s_q.conv == dacsr_pkg::CONV_RUN && sclk_rise)
                begin
                    s_d.conv_cnt = s_q.conv_cnt + 5'h01;
                    if (s_d.conv_cnt == dacsr_pkg::BUSY_CLR_EDGE)
                    begin
                        s_d.busy = 1'b0;
                    end
                    if (s_d.conv_cnt == dacsr_pkg::CONV_CYCLES)
                    begin
                        s_d.conv     = dacsr_pkg::CONV_IDLE;
                        s_d.res_code = s_q.hold_code;
                        s_d.res_pair = s_q.hold_pair;
                    end
                end
            end
            default:
            begin
                s_d.conv = dacsr_pkg::CONV_IDLE;
            end
        endcase

        // ****************************************
        // Serial readout
        // ****************************************
        // Tagged words per channel
        word_a = frame_word(s_q.res_pair, 1'b0, s_q.res_code[11:0]);
        word_b = frame_word(s_q.res_pair, 1'b1, s_q.res_code[23:12]);
        len    = s_q.frame_single ? dacsr_pkg::FRAME_LEN_1
                                  : dacsr_pkg::FRAME_LEN_2;
        if (sync_rise)
        begin
            s_d.frame_on     = 1'b1;
            s_d.frame_single = i_output_port_select;
            s_d.bit_idx      = '0;
        end
        else if (s_q.frame_on && sclk_rise)
        begin
            if (s_q.frame_single && s_q.bit_idx[4])
            begin
                s_d.sdo_a = word_b[4'hF - s_q.bit_idx[3:0]];
            end
            else
            begin
                s_d.sdo_a = word_a[4'hF - s_q.bit_idx[3:0]];
            end
            s_d.sdo_b   = s_q.frame_single ? 1'b0
                                           : word_b[4'hF - s_q.bit_idx[3:0]];
            s_d.bit_idx = s_q.bit_idx + 6'h01;
            if (s_d.bit_idx == len)
            begin
                s_d.frame_on = 1'b0;
            end
        end

        s_d.oe_a = ~i_chip_select_n;
        s_d.oe_b = ~i_chip_select_n & ~i_output_port_select;

        // ****************************************
        // Register bus
        // ****************************************
        // Zero wait states: answer is set up during the setup cycle
        s_d.apb.pready = req.psel & ~req.penable;
        if (req.psel && !req.penable)
        begin
            s_d.apb.pslverr = (sel == dacsr_pkg::SEL_NONE);
            case (sel)
                dacsr_pkg::SEL_STATUS:
                    s_d.apb.prdata = {29'h0, s_q.frame_on,
                                      s_q.pair_next, s_q.busy};
                dacsr_pkg::SEL_RESULT:
                    s_d.apb.prdata = {4'h0, s_q.res_code[23:12],
                                      3'h0, s_q.res_pair,
                                      s_q.res_code[11:0]};
                default:
                    s_d.apb.prdata = dacsr_pkg::RST_WORD;
            endcase
        end
        else
        begin
            s_d.apb.pslverr = 1'b0;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            s_q      <= '0;
            s_q.conv <= dacsr_pkg::CONV_IDLE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_pready   = s_q.apb.pready;
    assign o_pslverr  = s_q.apb.pslverr;
    assign o_prdata   = s_q.apb.prdata;
    assign o_busy     = s_q.busy;
    assign o_sdo_a    = s_q.sdo_a;
    assign o_sdo_a_oe = s_q.oe_a;
    assign o_sdo_b    = s_q.sdo_b;
    assign o_sdo_b_oe = s_q.oe_b;

endmodule

// *** verif/dacsr_props.sv ***
// Checker of busy timing, serial bit timing, output enables, bus answer.
// Assumes it is bound to dacsr_top and sees only its ports.
`timescale 1ns/1ps
module dacsr_props
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_shift_clock,
    input wire logic i_conversion_trigger,
    input wire logic i_chip_select_n,
    input wire logic i_output_port_select,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic o_pready,
    input wire logic o_busy,
    input wire logic o_sdo_a,
    input wire logic o_sdo_a_oe,
    input wire logic o_sdo_b_oe
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Rise seen last cycle; outputs lag it by one register
    sequence s_shift_rise;
        $past(i_shift_clock) && !$past(i_shift_clock, 2);
    endsequence
    sequence s_conv_start;
        $rose(o_busy);
    endsequence
    a_busy_start: assert property (
        $rose(i_conversion_trigger) && !o_busy |=> o_busy)
        else $error("busy did not follow trigger");
    a_busy_hold: assert property (
        s_conv_start |-> o_busy [*8])
        else $error("busy dropped too early");
    a_busy_bound: assert property (
        s_conv_start |-> ##[1:400] !o_busy)
        else $error("busy never cleared");
    a_busy_clear: assert property (
        !$past(i_sys_rst) && $fell(o_busy) |-> s_shift_rise)
        else $error("busy cleared off a shift rise");
    a_sdo_timing: assert property (
        !$past(i_sys_rst) && $changed(o_sdo_a) |-> s_shift_rise)
        else $error("serial bit moved off a shift rise");
    a_oe_a_on: assert property (
        !i_chip_select_n |=> o_sdo_a_oe)
        else $error("output A not driven");
    a_oe_b_off: assert property (
        i_chip_select_n || i_output_port_select |=> !o_sdo_b_oe)
        else $error("output B driven");
    a_apb_ready: assert property (
        i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("bus answer not one cycle");
endmodule

bind dacsr_top dacsr_props i_props
(
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_shift_clock(i_shift_clock),
    .i_conversion_trigger(i_conversion_trigger),
    .i_chip_select_n(i_chip_select_n),
    .i_output_port_select(i_output_port_select),
    .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready),
    .o_busy(o_busy), .o_sdo_a(o_sdo_a), .o_sdo_a_oe(o_sdo_a_oe),
    .o_sdo_b_oe(o_sdo_b_oe)
);

// *** verif/dacsr_host.sv ***
// Host side master clock source for the converter readout.
// Assumes a 40 MHz i_clk; makes 8 MHz, 2 cycles high, 3 low.
`timescale 1ns/1ps
module dacsr_host
(
    input  wire logic i_clk,
    input  wire logic i_run,
    output logic      o_shift_clock
);
    logic [2:0] cnt_q = 3'h0;
    // ****************************************
    // Clock generation
    // ****************************************
    // host supplies 8 MHz clock
    // Finishes the cycle, then stands low so no runt pulse
    always_ff @(posedge i_clk)
    begin
        if (i_run || cnt_q != 3'h0)
            cnt_q <= (cnt_q == 3'h4) ? 3'h0 : cnt_q + 3'h1;
    end
    assign o_shift_clock = (cnt_q == 3'h1) || (cnt_q == 3'h2);
endmodule

// *** verif/tb.sv ***
// Self-checking bench of the dual converter readout.
// Assumes dacsr_top, the host clock model and the bound checker.
`timescale 1ns/1ps
module tb;
    logic        clk = 0, rst = 1, trig = 0, sync = 0, cs_n = 1;
    logic        cm = 0, ops = 0, ps = 0, run = 0, sclk, tie = 0;
    logic        psel = 0, pen = 0, pwr = 0, pready, perr, er;
    logic        busy, sa, sa_oe, sb, sb_oe;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prdata, rd;
    logic [11:0] ca [2] = '{12'hA5C, 12'h5A3};
    logic [11:0] cb [2] = '{12'h3C1, 12'hC3E};
    int          failures = 0, compares = 0;
    dacsr_host i_host (.i_clk(clk), .i_run(run), .o_shift_clock(sclk));
    dacsr_top i_dut
    (
        .i_clk(clk), .i_sys_rst(rst), .i_shift_clock(sclk),
        .i_conversion_trigger(trig), .i_readout_sync(sync | (tie & trig)),
        .i_chip_select_n(cs_n), .i_channel_count_select(cm),
        .i_output_port_select(ops), .i_pair_select(ps),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
        .i_pwdata(pwd), .o_pready(pready), .o_pslverr(perr),
        .o_prdata(prdata), .o_busy(busy), .o_sdo_a(sa),
        .o_sdo_a_oe(sa_oe), .o_sdo_b(sb), .o_sdo_b_oe(sb_oe)
    );
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        if (failures == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Waits for the answer; only the watchdog ends a hang
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        // Idle cycle so two calls never drive psel twice at once
        @(posedge clk);
    endtask
    // Trigger with clock stopped, then sixteen shift cycles
    task conv(input logic p);
        trig <= 1'b1;
        repeat (2) @(posedge clk);
        trig <= 1'b0;
        run <= 1'b1;
        repeat (12) @(posedge sclk);
        @(negedge sclk);
        #1 chk(32'(busy), 32'h1);
        repeat (2) @(posedge sclk);
        @(negedge sclk);
        #1 chk(32'(busy), 32'h0);
        repeat (2) @(posedge sclk);
        @(posedge clk);
        run <= 1'b0;
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, {4'h0, cb[p], 3'h0, p, ca[p]});
    endtask
    task frame(input logic p);
        logic [31:0] ga, gb;
        int          i;
        sync <= 1'b1;
        @(posedge clk);
        sync <= 1'b0;
        repeat (4) @(posedge clk);
        run <= 1'b1;
        for (i = 0; i < (ops ? 32 : 16); i++)
        begin
            @(negedge sclk);
            #1 ga = {ga[30:0], sa};
            gb = {gb[30:0], sb};
        end
        @(posedge clk);
        run <= 1'b0;
        if (ops)
        begin
            chk(ga, {p, 1'b0, ca[p], 2'h0, p, 1'b1, cb[p], 2'h0});
            chk(32'(sb_oe), 32'h0);
        end
        else
        begin
            chk(32'(ga[15:0]), {16'h0, p, 1'b0, ca[p], 2'h0});
            chk(32'(gb[15:0]), {16'h0, p, 1'b1, cb[p], 2'h0});
        end
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b1, 12'h004, {4'h0, cb[0], 4'h0, ca[0]});
        apb(1'b1, 12'h008, {4'h0, cb[1], 4'h0, ca[1]});
        cs_n <= 1'b0;
        cm <= 1'b1;
        conv(1'b0);
        frame(1'b0);
        conv(1'b1);
        frame(1'b1);
        cm <= 1'b0;
        conv(1'b0);
        ps <= 1'b1;
        ops <= 1'b1;
        tie <= 1'b1;
        conv(1'b1);
        tie <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h4);
        frame(1'b1);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk(32'({sa_oe, sb_oe}), 32'h0);
        end_sim;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim;
    end
endmodule
